//--- hw/supply_supervisor_cfg.svh
// Timing counts and control field positions of the supply supervisor block
`ifndef SUPPLY_SUPERVISOR_CFG_SVH
`define SUPPLY_SUPERVISOR_CFG_SVH
`define CLK_MHZ               25
`define WAKE_SLOW_US          150
`define WAKE_FAST_US          2
`define SETTLE_SLOW_US        150
`define SETTLE_FAST_US        2
`define WAKE_SLOW_CYC         (`WAKE_SLOW_US * `CLK_MHZ)
`define WAKE_FAST_CYC         (`WAKE_FAST_US * `CLK_MHZ)
`define SETTLE_SLOW_CYC       (`SETTLE_SLOW_US * `CLK_MHZ)
`define SETTLE_FAST_CYC       (`SETTLE_FAST_US * `CLK_MHZ)
`define CNT_W                 12
// Low-side control field positions
`define LOW_SUP_EN_BIT        0
`define LOW_SUP_FP_BIT        1
`define LOW_SUP_KEEP_BIT      2
`define LOW_MON_EN_BIT        3
`define LOW_MON_FP_BIT        4
`define LOW_AUTO_BIT          5
// High-side control field positions
`define HIGH_SUP_EN_BIT       0
`define HIGH_SUP_FP_BIT       1
`define HIGH_SUP_KEEP_BIT     2
`define HIGH_MON_EN_BIT       3
`define HIGH_MON_FP_BIT       4
`define HIGH_AUTO_BIT         5
`define HIGH_OVP_BIT          6
`define CTL_W                 8
`define CTL_RESET             8'h00
`endif

//--- hw/supply_supervisor_pkg.sv
// Types shared by the supply supervisor design files
package supply_supervisor_pkg;
  typedef enum logic [1:0] {
    SUP_OFF  = 2'b00,
    SUP_NORM = 2'b01,
    SUP_FULL = 2'b10
  } sup_state_e;
  typedef enum logic [1:0] {
    PM_ACTIVE = 2'b00,
    PM_LIGHT  = 2'b01,
    PM_DEEP   = 2'b10
  } power_mode_e;
  typedef enum logic [1:0] {
    WK_IDLE = 2'b00,
    WK_HOLD = 2'b01,
    WK_RUN  = 2'b10
  } wake_state_e;
endpackage

//--- hw/timer_if.sv
// Start strobe, load count and busy level between the block and its delay timers
`timescale 1ns/1ns
`default_nettype none
interface timer_if;
  logic        start;
  logic [11:0] load;
  logic        busy;
  modport ctrl (output start, output load, input busy);
  modport tmr  (input start, input load, output busy);
endinterface // timer_if
`default_nettype wire

//--- hw/delay_timer.sv
// Reloadable down-counter that stays busy until its count expires
`timescale 1ns/1ns
`default_nettype none
`include "supply_supervisor_cfg.svh"
module delay_timer
(
  // Clock and reset
  input  wire logic  clk_i,
  input  wire logic  resetn_i,
  // Control
  timer_if.tmr       t
);
  logic [`CNT_W-1:0] cnt_ff;
  logic [`CNT_W-1:0] nxt_cnt;

  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (t.start)
    begin
      nxt_cnt = t.load;
    end
    else if (cnt_ff != '0)
    begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cnt_ff <= '0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign t.busy = (cnt_ff != '0);
endmodule // delay_timer
`default_nettype wire

//--- hw/supply_supervisor_mode_control.sv
// Supervisor mode control, wake-up hold-off and settling delay flags
//
// Summary of operation
// - Normal-mode low side holds CPU 150 us.
// - Off or full-performance low side holds 2 us.
// - Full-performance low side settles in 2 us.
// - Normal low side settles in 150 us.
// - Off or full-performance low side: fast wake.
// - Normal low supervisor: slow 150 us wake.
// - Control writes raise delay flags until settled.
// - High auto with normal monitor: off asleep.
// - Manual keep bit holds high side powered.
// - Overvoltage enable makes monitor issue reset.
`timescale 1ns/1ns
`default_nettype none
`include "supply_supervisor_cfg.svh"
module supply_supervisor_mode_control
  import supply_supervisor_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  // Control register writes
  input  wire logic              low_ctl_we_i,
  input  wire logic              high_ctl_we_i,
  input  wire logic [`CTL_W-1:0] ctl_wdata_i,
  // Power mode and wake-up
  input  wire logic [1:0]        power_mode_i,
  input  wire logic              wake_i,
  // Comparator inputs
  input  wire logic              low_supervisor_trip_i,
  input  wire logic              high_supervisor_trip_i,
  input  wire logic              high_monitor_over_i,
  // Status
  output logic [`CTL_W-1:0]      low_ctl_o,
  output logic [`CTL_W-1:0]      high_ctl_o,
  output logic                   low_side_delay_flag_o,
  output logic                   high_side_delay_flag_o,
  output logic                   fast_wake_o,
  output logic                   cpu_hold_o,
  // Supervisor states
  output logic [1:0]             low_supervisor_state_o,
  output logic [1:0]             low_monitor_state_o,
  output logic [1:0]             high_supervisor_state_o,
  output logic [1:0]             high_monitor_state_o,
  // Reset request
  output logic                   por_req_o
);
  // Delay lengths in clock cycles
  localparam logic [`CNT_W-1:0] WAKE_SLOW  = `CNT_W'(`WAKE_SLOW_CYC);
  localparam logic [`CNT_W-1:0] WAKE_FAST  = `CNT_W'(`WAKE_FAST_CYC);
  localparam logic [`CNT_W-1:0] SET_SLOW   = `CNT_W'(`SETTLE_SLOW_CYC);
  localparam logic [`CNT_W-1:0] SET_FAST   = `CNT_W'(`SETTLE_FAST_CYC);

  logic [`CTL_W-1:0] low_ctl_ff;
  logic [`CTL_W-1:0] nxt_low_ctl;
  logic [`CTL_W-1:0] high_ctl_ff;
  logic [`CTL_W-1:0] nxt_high_ctl;
  wake_state_e       wake_ff;
  wake_state_e       nxt_wake;
  logic              por_ff;
  logic              nxt_por;
  logic [1:0]        lss_ff;
  logic [1:0]        lms_ff;
  logic [1:0]        hss_ff;
  logic [1:0]        hms_ff;
  logic [1:0]        nxt_lss;
  logic [1:0]        nxt_lms;
  logic [1:0]        nxt_hss;
  logic [1:0]        nxt_hms;

  timer_if settle_low ();
  timer_if settle_high ();
  timer_if wake_tmr ();

  delay_timer u_settle_low
  (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .t        (settle_low.tmr)
  );

  delay_timer u_settle_high
  (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .t        (settle_high.tmr)
  );

  delay_timer u_wake
  (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .t        (wake_tmr.tmr)
  );

  // Field decode
  logic ls_en;
  logic ls_fp;
  logic ls_keep;
  logic lm_en;
  logic lm_fp;
  logic l_auto;
  logic hs_en;
  logic hs_fp;
  logic hs_keep;
  logic hm_en;
  logic hm_fp;
  logic h_auto;
  logic ovp_en;
  logic low_fast;
  logic asleep;

  assign ls_en   = low_ctl_ff[`LOW_SUP_EN_BIT];
  assign ls_fp   = low_ctl_ff[`LOW_SUP_FP_BIT];
  assign ls_keep = low_ctl_ff[`LOW_SUP_KEEP_BIT];
  assign lm_en   = low_ctl_ff[`LOW_MON_EN_BIT];
  assign lm_fp   = low_ctl_ff[`LOW_MON_FP_BIT];
  assign l_auto  = low_ctl_ff[`LOW_AUTO_BIT];
  assign hs_en   = high_ctl_ff[`HIGH_SUP_EN_BIT];
  assign hs_fp   = high_ctl_ff[`HIGH_SUP_FP_BIT];
  assign hs_keep = high_ctl_ff[`HIGH_SUP_KEEP_BIT];
  assign hm_en   = high_ctl_ff[`HIGH_MON_EN_BIT];
  assign hm_fp   = high_ctl_ff[`HIGH_MON_FP_BIT];
  assign h_auto  = high_ctl_ff[`HIGH_AUTO_BIT];
  assign ovp_en  = high_ctl_ff[`HIGH_OVP_BIT];
  // Light sleep keeps the active-mode states; only deep sleep changes them
  assign asleep  = (power_mode_i == PM_DEEP);

  // Slow wake only when an enabled low-side unit runs in normal mode
  assign low_fast = !((ls_en && !ls_fp) || (lm_en && !lm_fp));

  // Control registers and settling timers
  always_comb
  begin
    nxt_low_ctl  = low_ctl_ff;
    nxt_high_ctl = high_ctl_ff;
    if (low_ctl_we_i)
    begin
      nxt_low_ctl = ctl_wdata_i;
    end
    if (high_ctl_we_i)
    begin
      nxt_high_ctl = ctl_wdata_i;
    end
  end

  // Any control write restarts both settling delays
  assign settle_low.start  = low_ctl_we_i || high_ctl_we_i;
  assign settle_high.start = low_ctl_we_i || high_ctl_we_i;
  // Settling depends on the low-side mode, the one being written on a low-side write
  assign settle_low.load   = (low_ctl_we_i ? ctl_wdata_i[`LOW_SUP_FP_BIT] : ls_fp)
                             ? SET_FAST : SET_SLOW;
  assign settle_high.load  = (low_ctl_we_i ? ctl_wdata_i[`LOW_SUP_FP_BIT] : ls_fp)
                             ? SET_FAST : SET_SLOW;

  // Flags stay high while a timer runs or a write is in progress
  assign low_side_delay_flag_o  = settle_low.busy || settle_low.start;
  assign high_side_delay_flag_o = settle_high.busy || settle_high.start;

  // Per-mode supervisor states
  function automatic logic [1:0] mode_state(input logic en,
                                            input logic fp,
                                            input logic keep,
                                            input logic autoc,
                                            input logic slp);
    logic [1:0] s;
    s = SUP_OFF;
    if (!en)
    begin
      s = SUP_OFF;
    end
    else if (!slp)
    begin
      s = fp ? SUP_FULL : SUP_NORM;
    end
    else if (keep && !autoc)
    begin
      s = fp ? SUP_FULL : SUP_NORM;
    end
    else if (keep && autoc && fp)
    begin
      s = SUP_NORM;
    end
    else
    begin
      s = SUP_OFF;
    end
    return s;
  endfunction

  always_comb
  begin
    // Monitors have no keep bit and pass it as set
    nxt_lss = mode_state(ls_en, ls_fp, ls_keep, l_auto, asleep);
    nxt_lms = mode_state(lm_en, lm_fp, 1'b1, l_auto, asleep);
    // Manual keep holds the high side powered in sleep
    nxt_hss = mode_state(hs_en, hs_fp, hs_keep, h_auto, asleep);
    // Auto control drops a normal-mode high monitor in sleep
    nxt_hms = mode_state(hm_en, hm_fp, 1'b1, h_auto, asleep);
  end

  // Wake-up hold-off of the CPU
  always_comb
  begin
    nxt_wake       = wake_ff;
    wake_tmr.start = 1'b0;
    wake_tmr.load  = low_fast ? WAKE_FAST : WAKE_SLOW;
    case (wake_ff)
      WK_IDLE:
      begin
        if (asleep)
        begin
          nxt_wake = WK_RUN;
        end
      end
      WK_RUN:
      begin
        // Only a wake from deep sleep holds the CPU
        if (wake_i && power_mode_i == PM_DEEP)
        begin
          wake_tmr.start = 1'b1;
          nxt_wake       = WK_HOLD;
        end
        else if (!asleep)
        begin
          nxt_wake = WK_IDLE;
        end
      end
      WK_HOLD:
      begin
        // Release one cycle after the count runs out
        if (!wake_tmr.busy && !wake_tmr.start)
        begin
          nxt_wake = WK_IDLE;
        end
      end
      default:
      begin
        nxt_wake = WK_IDLE;
      end
    endcase
  end

  // Reset requests from tripped supervisors and overvoltage
  always_comb
  begin
    nxt_por = 1'b0;
    if (hms_ff != SUP_OFF && ovp_en && high_monitor_over_i)
    begin
      nxt_por = 1'b1;
    end
    // Supervisor trips count only once settling is over
    if (lss_ff != SUP_OFF && !low_side_delay_flag_o && low_supervisor_trip_i)
    begin
      nxt_por = 1'b1;
    end
    if (hss_ff != SUP_OFF && !high_side_delay_flag_o && high_supervisor_trip_i)
    begin
      nxt_por = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      low_ctl_ff  <= `CTL_RESET;
      high_ctl_ff <= `CTL_RESET;
      wake_ff     <= WK_IDLE;
      por_ff      <= 1'b0;
      lss_ff      <= SUP_OFF;
      lms_ff      <= SUP_OFF;
      hss_ff      <= SUP_OFF;
      hms_ff      <= SUP_OFF;
    end
    else
    begin
      low_ctl_ff  <= nxt_low_ctl;
      high_ctl_ff <= nxt_high_ctl;
      wake_ff     <= nxt_wake;
      por_ff      <= nxt_por;
      lss_ff      <= nxt_lss;
      lms_ff      <= nxt_lms;
      hss_ff      <= nxt_hss;
      hms_ff      <= nxt_hms;
    end
  end

  assign low_ctl_o               = low_ctl_ff;
  assign high_ctl_o              = high_ctl_ff;
  assign fast_wake_o             = low_fast;
  assign cpu_hold_o              = (wake_ff == WK_HOLD);
  assign low_supervisor_state_o  = lss_ff;
  assign low_monitor_state_o     = lms_ff;
  assign high_supervisor_state_o = hss_ff;
  assign high_monitor_state_o    = hms_ff;
  assign por_req_o               = por_ff;
endmodule // supply_supervisor_mode_control
`default_nettype wire

//--- verification/ssmc_chk.sv
// Concurrent checks on the supply supervisor mode control ports
`timescale 1ns/1ns
`default_nettype none
`include "supply_supervisor_cfg.svh"
module ssmc_chk
  import supply_supervisor_pkg::*;
(
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       resetn_i,
  // Inputs watched
  input wire logic       low_ctl_we_i,
  input wire logic       high_ctl_we_i,
  input wire logic [1:0] power_mode_i,
  input wire logic       wake_i,
  input wire logic       high_monitor_over_i,
  // Outputs watched
  input wire logic [7:0] low_ctl_o,
  input wire logic [7:0] high_ctl_o,
  input wire logic       low_side_delay_flag_o,
  input wire logic       high_side_delay_flag_o,
  input wire logic       fast_wake_o,
  input wire logic       cpu_hold_o,
  input wire logic [1:0] high_supervisor_state_o,
  input wire logic [1:0] high_monitor_state_o,
  input wire logic       por_req_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [11:0] wc_ff, nxt_wc, hc_ff, nxt_hc;
  int          lim, lh;
  assign lim = low_ctl_o[1] ? `SETTLE_FAST_CYC : `SETTLE_SLOW_CYC;
  assign lh = fast_wake_o ? `WAKE_FAST_CYC : `WAKE_SLOW_CYC;
  // Cycles since last write, and length of the running hold
  always_comb
  begin
    nxt_wc = (wc_ff == 12'h000 || wc_ff == 12'hFFF) ? wc_ff : wc_ff + 12'h001;
    if (low_ctl_we_i || high_ctl_we_i)
      nxt_wc = 12'h001;
    nxt_hc = cpu_hold_o ? hc_ff + 12'h001 : 12'h000;
  end
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wc_ff <= 12'h000;
      hc_ff <= 12'h000;
    end
    else
    begin
      wc_ff <= nxt_wc;
      hc_ff <= nxt_hc;
    end
  end
  property p_flag_wr;
    low_ctl_we_i || high_ctl_we_i |-> low_side_delay_flag_o && high_side_delay_flag_o;
  endproperty
  a_flag_wr: assert property (p_flag_wr) else $error("Delay flag low at write");
  property p_settle_hi;
    wc_ff != 12'h000 && wc_ff < lim |-> low_side_delay_flag_o && high_side_delay_flag_o;
  endproperty
  a_settle_hi: assert property (p_settle_hi) else $error("Flag dropped early");
  property p_settle_lo;
    wc_ff > lim + 1 && !low_ctl_we_i && !high_ctl_we_i |-> !low_side_delay_flag_o;
  endproperty
  a_settle_lo: assert property (p_settle_lo) else $error("Flag held too long");
  property p_fast;
    fast_wake_o == !(low_ctl_o[0] && !low_ctl_o[1] || low_ctl_o[3] && !low_ctl_o[4]);
  endproperty
  a_fast: assert property (p_fast) else $error("Wrong wake speed");
  property p_hold_go;
    $past(power_mode_i) == 2'h2 && power_mode_i == 2'h2 && wake_i && !cpu_hold_o
      && !$past(cpu_hold_o) |-> ##[1:2] cpu_hold_o;
  endproperty
  a_hold_go: assert property (p_hold_go) else $error("No hold after wake");
  property p_hold_len;
    $fell(cpu_hold_o) |-> hc_ff >= lh && hc_ff <= lh + 2;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("Wrong hold length");
  property p_mon_off;
    power_mode_i == 2'h2 && high_ctl_o[5] && high_ctl_o[3] && !high_ctl_o[4] && !high_ctl_we_i
      |=> high_monitor_state_o == SUP_OFF;
  endproperty
  a_mon_off: assert property (p_mon_off) else $error("Monitor on in sleep");
  property p_keep;
    power_mode_i == 2'h2 && !high_ctl_o[5] && high_ctl_o[2] && high_ctl_o[0] && !high_ctl_we_i
      |=> high_supervisor_state_o != SUP_OFF;
  endproperty
  a_keep: assert property (p_keep) else $error("Kept supervisor off");
  property p_ovp;
    high_ctl_o[6] && high_monitor_over_i && high_monitor_state_o != SUP_OFF
      && !high_side_delay_flag_o |-> ##[1:2] por_req_o;
  endproperty
  a_ovp: assert property (p_ovp) else $error("No reset on overvoltage");
endmodule // ssmc_chk
bind supply_supervisor_mode_control ssmc_chk ssmc_chk_inst (.clk_i, .resetn_i,
  .low_ctl_we_i, .high_ctl_we_i, .power_mode_i, .wake_i, .high_monitor_over_i, .low_ctl_o,
  .high_ctl_o, .low_side_delay_flag_o, .high_side_delay_flag_o, .fast_wake_o, .cpu_hold_o,
  .high_supervisor_state_o, .high_monitor_state_o, .por_req_o);
`default_nettype wire

//--- verification/supply_supervisor_mode_control_bench.sv
// Self-checking bench for the supply supervisor mode control block
`timescale 1ns/1ns
`default_nettype none
`include "supply_supervisor_cfg.svh"
module supply_supervisor_mode_control_bench
  import supply_supervisor_pkg::*;
;
  logic       clk_i = 1'b0;
  logic       resetn_i = 1'b0;
  logic       low_ctl_we_i = 1'b0, high_ctl_we_i = 1'b0, wake_i = 1'b0;
  logic       low_supervisor_trip_i = 1'b0, high_supervisor_trip_i = 1'b0;
  logic       high_monitor_over_i = 1'b0;
  logic [7:0] ctl_wdata_i = 8'h00, low_ctl_o, high_ctl_o;
  logic [1:0] power_mode_i = 2'h0;
  logic       low_side_delay_flag_o, high_side_delay_flag_o, fast_wake_o, cpu_hold_o, por_req_o;
  logic [1:0] low_supervisor_state_o, low_monitor_state_o;
  logic [1:0] high_supervisor_state_o, high_monitor_state_o;
  int         fail_count = 0, checks_done = 0, n;
  // Low word, high word, fast wake, low active state, high sleep states, low monitor sleep
  typedef struct packed {logic [7:0] lo, hi; logic fw; logic [1:0] ls, hs, hm, lm;} row_s;
  row_s rows [6] = '{'{8'h00, 8'h00, 1'b1, 2'h0, 2'h0, 2'h0, 2'h0},
                     '{8'h01, 8'h29, 1'b0, 2'h1, 2'h0, 2'h0, 2'h0},
                     '{8'h3B, 8'h05, 1'b1, 2'h2, 2'h1, 2'h0, 2'h1},
                     '{8'h08, 8'h07, 1'b0, 2'h0, 2'h2, 2'h0, 2'h1},
                     '{8'h03, 8'h3F, 1'b1, 2'h2, 2'h1, 2'h1, 2'h0},
                     '{8'h02, 8'h18, 1'b1, 2'h0, 2'h0, 2'h2, 2'h0}};
  supply_supervisor_mode_control supply_supervisor_mode_control_inst (.clk_i, .resetn_i,
    .low_ctl_we_i, .high_ctl_we_i, .ctl_wdata_i, .power_mode_i, .wake_i,
    .low_supervisor_trip_i, .high_supervisor_trip_i, .high_monitor_over_i, .low_ctl_o,
    .high_ctl_o, .low_side_delay_flag_o, .high_side_delay_flag_o, .fast_wake_o, .cpu_hold_o,
    .low_supervisor_state_o, .low_monitor_state_o, .high_supervisor_state_o,
    .high_monitor_state_o, .por_req_o);
  always #20 clk_i = ~clk_i;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h got %h", nm, e, g);
    end
  endtask
  // Counts may run up to two cycles past the nominal figure
  task automatic rng(input string nm, input int lo, input int g);
    checks_done++;
    if (g < lo || g > lo + 2)
    begin
      fail_count++;
      $display("[ERR] %s expected %0d got %0d", nm, lo, g);
    end
  endtask
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic rst_chk;
    chk("flags", 8'h00, {low_side_delay_flag_o, high_side_delay_flag_o, cpu_hold_o, por_req_o});
    chk("ctl", 8'h00, low_ctl_o | high_ctl_o);
    chk("fast", 8'h01, fast_wake_o);
    chk("state", 8'h00, {low_supervisor_state_o, low_monitor_state_o,
                         high_supervisor_state_o, high_monitor_state_o});
  endtask
  // Low write, gap, high write; returns cycles the delay flag stood from the high write
  task automatic wr(input logic [7:0] lo, input logic [7:0] hi, input int gap, output int c);
    @(negedge clk_i);
    low_ctl_we_i = 1'b1;
    ctl_wdata_i = lo;
    @(negedge clk_i);
    low_ctl_we_i = 1'b0;
    repeat (gap) @(negedge clk_i);
    high_ctl_we_i = 1'b1;
    ctl_wdata_i = hi;
    @(negedge clk_i);
    high_ctl_we_i = 1'b0;
    chk("hflag", 8'h01, high_side_delay_flag_o);
    c = 1;
    while (low_side_delay_flag_o === 1'b1 && c < 5000)
    begin
      c++;
      @(negedge clk_i);
    end
  endtask
  task automatic wk(input int nn);
    int c;
    c = 0;
    power_mode_i = 2'h2;
    repeat (2) @(negedge clk_i);
    wake_i = 1'b1;
    @(negedge clk_i);
    wake_i = 1'b0;
    repeat (4) if (cpu_hold_o !== 1'b1) @(negedge clk_i);
    while (cpu_hold_o === 1'b1 && c < 5000)
    begin
      c++;
      @(negedge clk_i);
    end
    rng("hold", nn, c);
    power_mode_i = 2'h0;
    repeat (100) @(negedge clk_i);
  endtask
  initial
  begin
    #2000000;
    fail_count++;
    end_sim();
  end
  initial
  begin
    repeat (2) @(negedge clk_i);
    rst_chk();
    resetn_i = 1'b1;
    foreach (rows[i])
    begin
      wr(rows[i].lo, rows[i].hi, 0, n);
      rng("settle", rows[i].lo[1] ? `SETTLE_FAST_CYC : `SETTLE_SLOW_CYC, n);
      chk("lo_ctl", rows[i].lo, low_ctl_o);
      chk("hi_ctl", rows[i].hi, high_ctl_o);
      chk("fast", rows[i].fw, fast_wake_o);
      chk("lsup", rows[i].ls, low_supervisor_state_o);
      power_mode_i = 2'h2;
      repeat (2) @(negedge clk_i);
      chk("hsup", rows[i].hs, high_supervisor_state_o);
      chk("hmon", rows[i].hm, high_monitor_state_o);
      chk("lmon", rows[i].lm, low_monitor_state_o);
      power_mode_i = 2'h0;
      repeat (2) @(negedge clk_i);
    end
    // A second write restarts the settling count
    wr(8'h03, 8'h00, 30, n);
    rng("restart", `SETTLE_FAST_CYC, n);
    // Light sleep keeps the active-mode state
    power_mode_i = 2'h1;
    repeat (2) @(negedge clk_i);
    chk("light", 8'h02, low_supervisor_state_o);
    power_mode_i = 2'h0;
    wk(`WAKE_FAST_CYC + 1);
    wr(8'h01, 8'h00, 0, n);
    wk(`WAKE_SLOW_CYC + 1);
    wr(8'h00, 8'h48, 0, n);
    high_monitor_over_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk("por", 8'h01, por_req_o);
    wr(8'h00, 8'h08, 0, n);
    repeat (3) @(negedge clk_i);
    chk("por_off", 8'h00, por_req_o);
    high_monitor_over_i = 1'b0;
    // Supervisor trips reset only once settling is over
    wr(8'h03, 8'h01, 0, n);
    high_supervisor_trip_i = 1'b1;
    @(negedge clk_i);
    chk("por_hi", 8'h01, por_req_o);
    high_supervisor_trip_i = 1'b0;
    low_supervisor_trip_i = 1'b1;
    @(negedge clk_i);
    chk("por_lo", 8'h01, por_req_o);
    low_ctl_we_i = 1'b1;
    ctl_wdata_i = 8'h03;
    @(negedge clk_i);
    low_ctl_we_i = 1'b0;
    chk("por_mask", 8'h00, por_req_o);
    low_supervisor_trip_i = 1'b0;
    // Reset in the middle of a settling delay
    @(negedge clk_i);
    low_ctl_we_i = 1'b1;
    ctl_wdata_i = 8'h1B;
    @(negedge clk_i);
    low_ctl_we_i = 1'b0;
    resetn_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rst_chk();
    resetn_i = 1'b1;
    wr(8'h03, 8'h00, 0, n);
    rng("settle", `SETTLE_FAST_CYC, n);
    end_sim();
  end
endmodule // supply_supervisor_mode_control_bench
`default_nettype wire
